/* voltage_id_cfg.svh */
// constants for the voltage-id input and general-purpose block
`ifndef VOLTAGE_ID_CFG_SVH
`define VOLTAGE_ID_CFG_SVH
`define REG_INT_STATUS_TWO 8'h42
`define REG_CODE_READBACK 8'h43
`define REG_INT_MASK_TWO 8'h75
`define REG_CONFIG_FIVE 8'h7c
`define BIT_CODE_CHANGE 0
`define BIT_THRESHOLD 6
`define BIT_SHARED_SEL 7
`define BIT_GP_MODE 4
`define BIT_PIN6_LO 2
`define BIT_MASK_CODE 0
`define CODE_BITS 6
`define CLK_MHZ 40
`define CHANGE_WINDOW_US 11
`define CHANGE_WINDOW_CYC (`CHANGE_WINDOW_US * `CLK_MHZ)
`define RESET_BYTE 8'h00
`endif

/* voltage_id_pkg.sv */
// types for the voltage-id input and general-purpose block
`default_nettype none
package voltage_id_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef enum logic [1:0] {
		pin6_input = 2'b00,
		pin6_out_low = 2'b01,
		pin6_out_high = 2'b10,
		pin6_alt = 2'b11
	} pin6_mode_e;
endpackage
`default_nettype wire

/* code_history_mem.sv */
// delay line holding past code samples, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "voltage_id_cfg.svh"
module code_history_mem
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// write side
	input wire logic wr_en_in,
	input wire logic [8:0] wr_addr_in,
	input wire logic [5:0] wr_data_in,
	// read side
	input wire logic [8:0] rd_addr_in,
	output logic [5:0] rd_data_out
);
	logic [5:0] mem_reg [0:511];
	logic [5:0] rd_reg;
	logic [5:0] rd_next;
	// read data always from a register
	always_comb
	begin
		rd_next = mem_reg[rd_addr_in];
	end
	// storage has no reset, only the output does
	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
		begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rd_reg <= 6'h00;
		end
		else
		begin
			rd_reg <= rd_next;
		end
	end
	assign rd_data_out = rd_reg;
endmodule
`default_nettype wire

/* voltage_id_and_gpio.sv */
// voltage-id readback, threshold select, code-change detect and gpio mode
// Functional notes
// - Readback bits 0 to 4 mirror the five dedicated code pins in order.
// - Readback bit 5 reads zero in 12 V mode and follows the shared pin in code mode.
// - Readback bit 6 selects the input threshold, zero nominal, one reduced.
// - Readback bit 7 selects the shared pin function and reads back.
// - With the selector zero, status bit 0 reports the 12 V limit fault.
// - With the selector one, status bit 0 reports code changes.
// - The change detector runs only while the shared pin is a code input.
// - A change flag sets when present code differs from the code 11 us earlier.
// - A code change raises the alert unless mask bit 0 is set.
// - Config five bit 4 turns the five dedicated code pins, and the shared pin when selector bit 7 is one, into general-purpose outputs.
// - In general-purpose mode writes to code bits set the output levels.
// - Pin six direction and function come from config five bits 3 to 2.
// - The code inputs are digital inputs read back through the combined register.
`timescale 1ns/1ps
`default_nettype none
`include "voltage_id_cfg.svh"
module voltage_id_and_gpio
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register access port
	input wire voltage_id_pkg::reg_req_s req_in,
	output logic [7:0] rd_data_out,
	// code pins
	input wire logic [5:0] code_pins_in,
	output logic [5:0] code_pins_out,
	output logic [5:0] code_pins_oe_out,
	// pin six
	input wire logic pin_six_in,
	output logic pin_six_out,
	output logic pin_six_oe_out,
	// analog side and alert
	input wire logic twelve_volt_fault_in,
	output logic input_threshold_select_out,
	output logic alert_n_out
);
	localparam logic [8:0] WIN_LAST = 9'(`CHANGE_WINDOW_CYC - 1);
	// synchronisers
	logic [5:0] sync1_reg, sync2_reg;
	logic p6_sync1_reg, p6_sync2_reg;
	logic fault_sync1_reg, fault_sync2_reg;
	// registers
	logic [7:0] readback_reg, readback_next;
	logic [7:0] mask_reg, mask_next;
	logic [7:0] cfg5_reg, cfg5_next;
	logic [5:0] gp_level_reg, gp_level_next;
	logic change_flag_reg, change_flag_next;
	logic [8:0] ptr_reg, ptr_next;
	logic warm_reg, warm_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic [5:0] pins_out_reg, pins_out_next, pins_oe_reg, pins_oe_next;
	logic p6_out_reg, p6_out_next, p6_oe_reg, p6_oe_next;
	logic alert_n_reg, alert_n_next;
	logic thr_reg, thr_next;
	logic [5:0] code_now, past_code;
	logic gp_mode, shared_sel, change_seen, status_read, detect_on;
	voltage_id_pkg::pin6_mode_e p6_mode;
	// -----------------------------------------------------------------
	// input capture
	// -----------------------------------------------------------------
	// pins are asynchronous, two flops before any use
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
			p6_sync1_reg <= 1'b0;
			p6_sync2_reg <= 1'b0;
			fault_sync1_reg <= 1'b0;
			fault_sync2_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= code_pins_in;
			sync2_reg <= sync1_reg;
			p6_sync1_reg <= pin_six_in;
			p6_sync2_reg <= p6_sync1_reg;
			fault_sync1_reg <= twelve_volt_fault_in;
			fault_sync2_reg <= fault_sync1_reg;
		end
	end
	assign shared_sel = readback_reg[`BIT_SHARED_SEL];
	assign gp_mode = cfg5_reg[`BIT_GP_MODE];
	assign p6_mode = voltage_id_pkg::pin6_mode_e'(cfg5_reg[`BIT_PIN6_LO+1:`BIT_PIN6_LO]);
	// code view
	// bit 5 forced low when the shared pin measures 12 V
	assign code_now = {sync2_reg[5] & shared_sel, sync2_reg[4:0]};
	// -----------------------------------------------------------------
	// change detector
	// -----------------------------------------------------------------
	// a 440-deep ring gives the sample taken 11 us ago
	code_history_mem u_hist
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(1'b1),
		.wr_addr_in(ptr_reg),
		.wr_data_in(code_now),
		.rd_addr_in(ptr_next),
		.rd_data_out(past_code)
	);
	// compare against delayed code
	// compare is held off until the ring has filled once
	// ring restarts while detection is off, so samples taken in 12 v or gpio
	// mode never look like a change once detection resumes
	assign detect_on = shared_sel && !gp_mode;
	assign change_seen = detect_on && warm_reg && (past_code != code_now);
	assign status_read = req_in.rd && (req_in.addr == `REG_INT_STATUS_TWO);
	always_comb
	begin
		ptr_next = (!detect_on || ptr_reg == WIN_LAST) ? 9'h000 : ptr_reg + 9'h001;
		warm_next = detect_on && (warm_reg || ptr_reg == WIN_LAST);
		change_flag_next = change_flag_reg;
		if (status_read)
		begin
			change_flag_next = 1'b0;
		end
		if (change_seen)
		begin
			change_flag_next = 1'b1;
		end
		if (!shared_sel)
		begin
			change_flag_next = 1'b0;
		end
	end
	// -----------------------------------------------------------------
	// register access
	// -----------------------------------------------------------------
	always_comb
	begin
		readback_next = readback_reg;
		mask_next = mask_reg;
		cfg5_next = cfg5_reg;
		gp_level_next = gp_level_reg;
		rd_data_next = 8'h00;
		if (req_in.wr)
		begin
			if (req_in.addr == `REG_CODE_READBACK)
			begin
				readback_next = {req_in.data[7:6], 6'h00};
				gp_level_next = req_in.data[5:0];
			end
			else if (req_in.addr == `REG_INT_MASK_TWO)
			begin
				mask_next = req_in.data;
			end
			else if (req_in.addr == `REG_CONFIG_FIVE)
			begin
				cfg5_next = req_in.data;
			end
		end
		if (req_in.rd)
		begin
			if (req_in.addr == `REG_CODE_READBACK)
			begin
				// bit 5 low in 12 v mode
				// gpio levels included, the shared pin is not an output then
				rd_data_next = {readback_reg[7:6], gp_mode ?
					{gp_level_reg[5] & shared_sel, gp_level_reg[4:0]} : code_now};
			end
			else if (req_in.addr == `REG_INT_STATUS_TWO)
			begin
				rd_data_next = {7'h00, shared_sel ? change_flag_reg : fault_sync2_reg};
			end
			else if (req_in.addr == `REG_INT_MASK_TWO)
			begin
				rd_data_next = mask_reg;
			end
			else if (req_in.addr == `REG_CONFIG_FIVE)
			begin
				rd_data_next = cfg5_reg;
			end
		end
	end
	// -----------------------------------------------------------------
	// pin drive
	// -----------------------------------------------------------------
	always_comb
	begin
		// gp mode turns code inputs into outputs
		pins_oe_next = gp_mode ? {shared_sel, 5'h1f} : 6'h00;
		pins_out_next = gp_mode ? (gp_level_reg & pins_oe_next) : 6'h00;
		p6_oe_next = (p6_mode == voltage_id_pkg::pin6_out_low) ||
			(p6_mode == voltage_id_pkg::pin6_out_high);
		p6_out_next = (p6_mode == voltage_id_pkg::pin6_out_high);
		alert_n_next = !(change_flag_reg && shared_sel && !mask_reg[`BIT_MASK_CODE]);
		thr_next = readback_reg[`BIT_THRESHOLD];
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			readback_reg <= `RESET_BYTE;
			mask_reg <= `RESET_BYTE;
			cfg5_reg <= `RESET_BYTE;
			gp_level_reg <= 6'h00;
			change_flag_reg <= 1'b0;
			ptr_reg <= 9'h000;
			warm_reg <= 1'b0;
			rd_data_reg <= 8'h00;
			pins_out_reg <= 6'h00;
			pins_oe_reg <= 6'h00;
			p6_out_reg <= 1'b0;
			p6_oe_reg <= 1'b0;
			alert_n_reg <= 1'b1;
			thr_reg <= 1'b0;
		end
		else
		begin
			readback_reg <= readback_next;
			mask_reg <= mask_next;
			cfg5_reg <= cfg5_next;
			gp_level_reg <= gp_level_next;
			change_flag_reg <= change_flag_next;
			ptr_reg <= ptr_next;
			warm_reg <= warm_next;
			rd_data_reg <= rd_data_next;
			pins_out_reg <= pins_out_next;
			pins_oe_reg <= pins_oe_next;
			p6_out_reg <= p6_out_next;
			p6_oe_reg <= p6_oe_next;
			alert_n_reg <= alert_n_next;
			thr_reg <= thr_next;
		end
	end
	assign rd_data_out = rd_data_reg;
	assign code_pins_out = pins_out_reg;
	assign code_pins_oe_out = pins_oe_reg;
	assign pin_six_out = p6_out_reg;
	assign pin_six_oe_out = p6_oe_reg;
	assign alert_n_out = alert_n_reg;
	assign input_threshold_select_out = thr_reg;
	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_change;
		change_seen;
	endsequence
	sequence s_flag_up;
		##1 change_flag_reg;
	endsequence
	a_change_sets_flag: assert property (s_change |-> s_flag_up)
		else $error("change not flagged");
	a_flag_holds_unread: assert property (change_flag_reg && !status_read && shared_sel
		|=> change_flag_reg)
		else $error("flag lost before read");
	a_alert_from_flag: assert property (change_flag_reg && shared_sel && !mask_reg[0]
		|=> !alert_n_out)
		else $error("alert missing");
	a_alert_masked: assert property (mask_reg[0] |=> alert_n_out)
		else $error("masked alert raised");
	a_detect_gated: assert property (!shared_sel |=> !change_flag_reg)
		else $error("detector active in 12 v mode");
	a_bit5_zero: assert property (req_in.rd && req_in.addr == 8'h43 && !shared_sel
		|=> !rd_data_out[5])
		else $error("bit 5 not zero");
	a_gp_drive: assert property ($rose(gp_mode) |=> code_pins_oe_out[4:0] == 5'h1f)
		else $error("gp outputs not enabled");
	a_thr_follow: assert property (
		##1 input_threshold_select_out == $past(readback_reg[6]))
		else $error("threshold not driven");
	a_pin6_dir: assert property (cfg5_reg[3:2] == 2'b00 |=> !pin_six_oe_out)
		else $error("pin six driven as input");
endmodule
`default_nettype wire

/* vr_code_model.sv */
// model of the regulator code lines seen at the block's code pins
`timescale 1ns/1ps
`default_nettype none
module vr_code_model
(
	// clock
	input wire logic clk_in,
	// requested code and answer lag
	input wire logic [5:0] code_in,
	input wire logic [1:0] lag_in,
	// lines the block drives itself
	input wire logic [5:0] oe_in,
	// line levels offered by the regulator
	output logic [5:0] line_out
);
	logic [5:0] held_reg = 6'h00;
	logic [1:0] lag_reg = 2'h0;
	// a new code shows only after the lag, as a slow regulator would
	always_ff @(posedge clk_in)
	begin
		if (code_in != held_reg && lag_reg < lag_in)
			lag_reg <= lag_reg + 2'h1;
		else
		begin
			held_reg <= code_in;
			lag_reg <= 2'h0;
		end
	end
	// lines the block drives offer the inverse so a stale level never matches
	assign line_out = held_reg ^ oe_in;
endmodule
`default_nettype wire

/* voltage_id_and_gpio_tb_top.sv */
// self-checking bench for the voltage-id and gpio block
`timescale 1ns/1ps
`default_nettype none
`include "voltage_id_cfg.svh"
module voltage_id_and_gpio_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic fault = 1'b0;
	logic six = 1'b0;
	voltage_id_pkg::reg_req_s req = '0;
	logic [7:0] rd;
	logic [5:0] pins_out, oe, line;
	logic [5:0] code = 6'h00;
	logic [1:0] lag = 2'h0;
	logic six_out, six_oe, thr, alert_n;
	logic [31:0] seed = 32'h6e25ace0;
	int bad_count = 0;
	int num_checks = 0;
	// wire level: the block wins where it drives
	wire logic [5:0] pins_in = (oe & pins_out) | (~oe & line);
	// clock
	initial forever #12.5 clk_in = ~clk_in;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	voltage_id_and_gpio u_voltage_id_and_gpio (.clk_in(clk_in), .rst_in(rst_in),
		.req_in(req), .rd_data_out(rd), .code_pins_in(pins_in), .code_pins_out(pins_out),
		.code_pins_oe_out(oe), .pin_six_in(six), .pin_six_out(six_out),
		.pin_six_oe_out(six_oe), .twelve_volt_fault_in(fault),
		.input_threshold_select_out(thr), .alert_n_out(alert_n));
	vr_code_model u_vr_code_model (.clk_in(clk_in), .code_in(code), .lag_in(lag),
		.oe_in(oe), .line_out(line));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// pin six {oe, level} per mode; input and alt leave it undriven
	function automatic logic [1:0] pin6_exp(input logic [1:0] m);
		return (m == 2'b01) ? 2'b10 : (m == 2'b10) ? 2'b11 : 2'b00;
	endfunction
	task complete_run;
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_in);
		req <= '0;
	endtask
	// read data stands one cycle after the read edge
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_in);
		req <= '0;
		#1 chk(rd, exp);
	endtask
	// lag of up to 3, two sync flops and margin fit in 8 cycles
	task set_code(input logic [5:0] c);
		@(posedge clk_in);
		code <= c;
		lag <= seed[1:0];
		six <= seed[7];
		seed = lfsr(seed);
		cyc(8);
	endtask
	task wait_alert;
		int i;
		for (i = 0; i < 20 && alert_n !== 1'b0; i++)
			@(posedge clk_in);
		if (alert_n !== 1'b0)
		begin
			bad_count++;
			$display("BAD %0t alert never asserted", $time);
			complete_run();
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		cyc(5);
		rst_in <= 1'b0;
		chk({7'h00, thr}, 8'h00); // nominal after reset
		for (int k = 0; k < 6; k++)
		begin
			seed = lfsr(seed);
			set_code((k == 0) ? 6'h3f : seed[5:0]);
			rd_chk(`REG_CODE_READBACK, {3'b000, code[4:0]});
		end
		@(posedge clk_in);
		fault <= 1'b1;
		cyc(4);
		rd_chk(`REG_INT_STATUS_TWO, 8'h01); // fault shown
		wr(`REG_CODE_READBACK, 8'hc0);
		// threshold output lands one edge after the write is taken
		cyc(1);
		#1 chk({7'h00, thr}, 8'h01); // reduced threshold
		rd_chk(`REG_CODE_READBACK, {2'b11, code});
		rd_chk(`REG_INT_STATUS_TWO, 8'h00); // fault hidden
		// history needs a full window of code-mode samples first
		cyc(460);
		set_code(code ^ 6'h20);
		wait_alert(); // alert on change
		rd_chk(`REG_INT_STATUS_TWO, 8'h01);
		cyc(460);
		rd_chk(`REG_INT_STATUS_TWO, 8'h01); // held until read
		rd_chk(`REG_INT_STATUS_TWO, 8'h00); // quiet window
		chk({7'h00, alert_n}, 8'h01); // alert released
		wr(`REG_INT_MASK_TWO, 8'h01);
		set_code(code ^ 6'h01);
		chk({7'h00, alert_n}, 8'h01); // masked change
		rd_chk(`REG_INT_STATUS_TWO, 8'h01); // still flagged
		wr(`REG_CODE_READBACK, 8'h00);
		wr(`REG_INT_MASK_TWO, 8'h00);
		@(posedge clk_in);
		fault <= 1'b0;
		set_code(code ^ 6'h02);
		chk({7'h00, alert_n}, 8'h01); // no alert in 12 V mode
		rd_chk(`REG_INT_STATUS_TWO, 8'h00); // idle in 12 V mode
		wr(`REG_CODE_READBACK, 8'h80);
		wr(`REG_CONFIG_FIVE, 8'h10);
		seed = lfsr(seed);
		wr(`REG_CODE_READBACK, {2'b10, seed[5:0]});
		cyc(2);
		chk({2'b00, oe}, 8'h3f); // all code pins drive
		chk({2'b00, pins_out}, {2'b00, seed[5:0]}); // written levels
		rd_chk(`REG_CODE_READBACK, {2'b10, seed[5:0]});
		for (int m = 0; m < 4; m++)
		begin
			wr(`REG_CONFIG_FIVE, {4'h1, 2'(m), 2'b00});
			cyc(2);
			chk({6'h00, six_oe, six_out}, {6'h00, pin6_exp(2'(m))}); // pin six modes
		end
		// gpio mode with the shared pin measuring 12 v
		wr(`REG_CODE_READBACK, 8'h3f);
		rd_chk(`REG_CODE_READBACK, 8'h1f); // bit 5 zero in gpio
		cyc(1);
		chk({2'b00, oe}, 8'h1f); // shared pin not driven
		complete_run();
	end
endmodule
`default_nettype wire
